// file: common/gearbox_pkg.sv
// Shared types and constants for the output serializer gearbox.
// Assumes one clock domain; mode is driven by logic on that clock.
package gearbox_pkg;

  localparam int unsigned WORD_W = 8;
  localparam int unsigned CNT_W = 3;

  // Serialization modes
  typedef enum logic [1:0] {
    video_seven_mode = 2'b00,
    ddr_eight_to_one_mode = 2'b01,
    ddr_four_to_one_mode = 2'b10
  } gear_mode_t;

  // Last bit index of a word per mode (length minus one)
  localparam logic [CNT_W-1:0] VIDEO_LAST = 3'h6;
  localparam logic [CNT_W-1:0] EIGHT_LAST = 3'h7;
  localparam logic [CNT_W-1:0] FOUR_LAST = 3'h3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;

  // Only bits 6 to 0 are used in video mode
  localparam logic [WORD_W-1:0] VIDEO_MASK = 8'h7F;
  localparam logic [WORD_W-1:0] WORD_ZERO = 8'h00;

  // Level of the serial outputs while reset or idle
  localparam logic IDLE_LEVEL = 1'b0;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic valid;
  } par_word_t;

  typedef struct packed {
    logic [WORD_W-1:0] hold;
    logic hold_full;
    logic [WORD_W-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic busy;
    gear_mode_t mode;
    logic out_a;
    logic out_b;
    logic first;
  } gear_state_t;

endpackage

// file: hdl/output_serializer_gearbox.sv
// Output gearbox of one top-edge io_cell: parallel core words in, serial out.
// Assumes core data, handshake and mode all come from the sys_clk domain.
`timescale 1ns/1ps
module output_serializer_gearbox
  import gearbox_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire gearbox_pkg::gear_mode_t mode,
  input wire gearbox_pkg::par_word_t par_in,
  output logic word_ready,
  output logic serial_out,
  output logic serial_out_b,
  output logic word_first
);
  import gearbox_pkg::*;

  // Width of each half of the word in dual four-to-one mode
  localparam int unsigned HALF_W = WORD_W / 2;
  // Number of independent halves in dual four-to-one mode
  localparam int unsigned HALF_CNT = 2;
  // Step of the bit counter
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  gear_state_t st;
  gear_state_t next_st;
  logic load;
  logic take;
  logic shifting;
  logic dual_mode;
  logic [CNT_W-1:0] last_idx;
  logic [WORD_W-1:0] in_word;
  logic [WORD_W-1:0] hold_single;
  logic [WORD_W-1:0] hold_dual;
  logic [WORD_W-1:0] shift_single;
  logic [WORD_W-1:0] shift_dual;

  // Shifter is free once idle or on its last bit, so words flow seamlessly
  assign load = st.hold_full && (!st.busy || st.cnt == CNT_ZERO);
  // Capture register accepts whenever it is empty or emptying this cycle
  assign word_ready = !st.hold_full || load;
  assign take = par_in.valid && word_ready;
  // Shifter still has bits of the current word to put out
  assign shifting = st.busy && st.cnt != CNT_ZERO;
  // The mode captured with the word decides the split, not the mode pin,
  // but the next capture replaces it, so a word still shifting can be torn
  assign dual_mode = st.mode == ddr_four_to_one_mode;

  assign serial_out = st.out_a;
  assign serial_out_b = st.out_b;
  assign word_first = st.first;

  // Whole word moves one place towards bit 0; the top fills with zero
  assign hold_single = {1'h0, st.hold[WORD_W-1:1]};
  assign shift_single = {1'h0, st.shift[WORD_W-1:1]};

  // Each half moves on its own, so a bit of the upper half never
  // crosses into the lower gearbox in dual mode
  genvar h;
  generate
    for (h = 0; h < HALF_CNT; h++)
    begin : g_half
      assign hold_dual[h*HALF_W +: HALF_W] =
        {1'h0, st.hold[h*HALF_W+1 +: HALF_W-1]};
      assign shift_dual[h*HALF_W +: HALF_W] =
        {1'h0, st.shift[h*HALF_W+1 +: HALF_W-1]};
    end
  endgenerate

  // Limitation: one clock serves both the core side and the fast side,
  // so one bit per serial output leaves per clock; a true double-rate edge is not modelled.
  always_comb
  begin
    next_st = st;
    last_idx = EIGHT_LAST;
    in_word = par_in.word;
    // Mode is sampled with each captured word; the next capture can change the split of one still shifting
    case (mode)
      video_seven_mode:
      begin
        // The unused top bit is dropped at capture, never sent
        in_word = par_in.word & VIDEO_MASK;
      end
      ddr_eight_to_one_mode:
      begin
        in_word = par_in.word;
      end
      ddr_four_to_one_mode:
      begin
        in_word = par_in.word;
      end
      default:
      begin
        in_word = par_in.word;
      end
    endcase
    // Word length comes from the mode captured with the word;
    // the reserved code runs as eight-to-one
    case (st.mode)
      video_seven_mode:
      begin
        last_idx = VIDEO_LAST;
      end
      ddr_eight_to_one_mode:
      begin
        last_idx = EIGHT_LAST;
      end
      ddr_four_to_one_mode:
      begin
        last_idx = FOUR_LAST;
      end
      default:
      begin
        last_idx = EIGHT_LAST;
      end
    endcase
    if (load)
    begin
      // Stage two: capture register hands over to the shifter
      next_st.hold_full = 1'h0;
      next_st.busy = 1'h1;
      next_st.cnt = last_idx;
      next_st.first = 1'h1;
      next_st.out_a = st.hold[0];
      if (dual_mode)
      begin
        // Two independent halves, each LSB first
        next_st.out_b = st.hold[HALF_W];
        next_st.shift = hold_dual;
      end
      else
      begin
        next_st.out_b = IDLE_LEVEL;
        next_st.shift = hold_single;
      end
    end
    else if (shifting)
    begin
      // Stage three: one bit per clock onto the serial output
      next_st.out_a = st.shift[0];
      next_st.first = 1'h0;
      next_st.cnt = st.cnt - CNT_ONE;
      if (dual_mode)
      begin
        next_st.out_b = st.shift[HALF_W];
        next_st.shift = shift_dual;
      end
      else
      begin
        next_st.out_b = IDLE_LEVEL;
        next_st.shift = shift_single;
      end
    end
    else
    begin
      // Starved: park the line rather than repeat stale bits
      next_st.busy = 1'h0;
      next_st.first = 1'h0;
      next_st.cnt = CNT_ZERO;
      next_st.shift = WORD_ZERO;
      next_st.out_a = IDLE_LEVEL;
      next_st.out_b = IDLE_LEVEL;
    end
    if (take)
    begin
      // Stage one: capture the core word
      next_st.hold = in_word;
      next_st.hold_full = 1'h1;
      next_st.mode = mode;
    end
    else
    begin
      // A refused or absent word leaves the capture register as it was;
      // its contents stay until the shifter takes them
      next_st.hold = st.hold;
      next_st.mode = st.mode;
    end
  end

  // Reset clears every stage so no half word survives into the next run
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st.hold <= WORD_ZERO;
      st.hold_full <= 1'h0;
      st.shift <= WORD_ZERO;
      st.cnt <= CNT_ZERO;
      st.busy <= 1'h0;
      st.mode <= ddr_eight_to_one_mode;
      st.out_a <= IDLE_LEVEL;
      st.out_b <= IDLE_LEVEL;
      st.first <= 1'h0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule // output_serializer_gearbox

// file: verification/gearbox_properties.sv
// Port checker for the gearbox.
// Bound by name to the output_serializer_gearbox module.
`timescale 1ns/1ps
module gearbox_properties
  import gearbox_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire gearbox_pkg::gear_mode_t mode,
  input wire gearbox_pkg::par_word_t par_in,
  input wire logic word_ready,
  input wire logic serial_out,
  input wire logic serial_out_b,
  input wire logic word_first
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_reset_idle: assert property (disable iff (1'b0) !rst_n |->
    word_ready && !serial_out && !word_first) else $error("reset");
  a_take_answer: assert property (par_in.valid && word_ready
    |-> ##[2:10] word_first) else $error("no load");
  a_lsb_first: assert property (word_first && $past(par_in.valid, 2)
    && $past(word_ready, 2) |-> serial_out == $past(par_in.word[0], 2)
    ##1 serial_out == $past(par_in.word[1], 3)) else $error("order");
  a_half_split: assert property (word_first && $past(par_in.valid, 2)
    && $past(mode, 2) == ddr_four_to_one_mode
    |-> serial_out_b == $past(par_in.word[4], 2)) else $error("split");
  // Cycles since the mode pin last asked for dual mode, saturating
  logic [3:0] quiet_cycles;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      quiet_cycles <= 4'h0;
    else if (mode == ddr_four_to_one_mode)
      quiet_cycles <= 4'h0;
    else if (quiet_cycles != 4'hF)
      quiet_cycles <= quiet_cycles + 4'h1;
  end
  a_b_quiet: assert property (quiet_cycles == 4'hF
    |-> !serial_out_b) else $error("b");
  a_eight_len: assert property (mode == ddr_eight_to_one_mode
    && word_first |-> ##1 !word_first [*7]) else $error("len8");
  a_video_len: assert property (mode == video_seven_mode
    && word_first |-> ##1 !word_first [*6]) else $error("len7");
endmodule // gearbox_properties
bind output_serializer_gearbox gearbox_properties i_props (.sys_clk, .rst_n,
  .mode, .par_in, .word_ready, .serial_out, .serial_out_b, .word_first);

// file: verification/serial_receiver_model.sv
// Far-side receiver: gathers bits LSB first.
// Samples at falling edges, where outputs are settled.
`timescale 1ns/1ps
module serial_receiver_model
(
  input wire logic sys_clk,
  input wire logic serial_out,
  input wire logic serial_out_b,
  input wire logic word_first,
  output logic [7:0] rx,
  output logic [3:0] rx_b
);
  logic [3:0] idx = 4'h8;
  always @(negedge sys_clk)
  begin
    if (word_first) idx = 4'h0;
    if (idx < 4'h8) rx[idx[2:0]] = serial_out;
    if (idx < 4'h4) rx_b[idx[1:0]] = serial_out_b;
    if (idx < 4'h8) idx = idx + 4'h1;
  end
endmodule // serial_receiver_model

// file: verification/tb.sv
// Bench: core word driver and receiver model.
// Inputs change at falling edges.
`timescale 1ns/1ps
module tb;
  import gearbox_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  gear_mode_t mode = ddr_eight_to_one_mode;
  par_word_t par_in = '0;
  logic word_ready, serial_out, serial_out_b, word_first;
  logic [7:0] rx;
  logic [3:0] rx_b;
  int mismatches = 0;
  int samples_checked = 0;
  always #5 sys_clk = ~sys_clk;
  output_serializer_gearbox i_dut (.sys_clk, .rst_n, .mode, .par_in,
    .word_ready, .serial_out, .serial_out_b, .word_first);
  serial_receiver_model i_rx (.sys_clk, .serial_out, .serial_out_b,
    .word_first, .rx, .rx_b);
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("mismatches %0d checks %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task offer(input logic [7:0] w);
    int n;
    n = 0;
    @(negedge sys_clk);
    par_in = '{w, 1'b1};
    while (word_ready !== 1'b1 && n < 20)
    begin
      n++;
      @(negedge sys_clk);
    end
    if (word_ready !== 1'b1)
    begin
      mismatches++;
      finish_test;
    end
    else
      @(posedge sys_clk);
  endtask
  // Two words back to back, then drain long enough for both
  task send_pair(input gear_mode_t m, input logic [7:0] a, b);
    @(negedge sys_clk);
    mode = m;
    offer(a);
    offer(b);
    @(negedge sys_clk);
    par_in.valid = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask
  task test_video;
    send_pair(video_seven_mode, 8'h3C, 8'hD5);
    check(rx & VIDEO_MASK, 8'h55);
  endtask
  task test_eight;
    send_pair(ddr_eight_to_one_mode, 8'hA1, 8'h96);
    check(rx, 8'h96);
  endtask
  task test_dual;
    send_pair(ddr_four_to_one_mode, 8'h5A, 8'hC3);
    check({4'h0, rx[3:0]}, 8'h03);
    check({4'h0, rx_b}, 8'h0C);
  endtask
  task test_reset;
    offer(8'hFF);
    @(negedge sys_clk);
    par_in.valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b0;
    @(negedge sys_clk);
    check({word_ready, serial_out, word_first}, 8'h04);
    rst_n = 1'b1;
    @(negedge sys_clk);
    check({word_ready, serial_out, serial_out_b, word_first}, 8'h08);
    repeat (2) @(negedge sys_clk);
    check({serial_out, word_first}, 8'h00);
  endtask
  initial
  begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    test_video;
    test_eight;
    test_dual;
    test_reset;
    test_eight;
    finish_test;
  end
endmodule // tb
